//--- rtl/sdm_pkg.sv
// ****************************************************************
// Constants and types of the door monitor
// ****************************************************************
package sdm_pkg;

   // Bus geometry
   localparam int unsigned AXI_ADDR_W = 4;
   localparam int unsigned AXI_DATA_W = 32;

   // Register byte offsets
   localparam logic [AXI_ADDR_W-1:0] OFS_SERVICE = 4'h0;
   localparam logic [AXI_ADDR_W-1:0] OFS_CONTROL = 4'h4;
   localparam logic [AXI_ADDR_W-1:0] OFS_STATUS  = 4'h8;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register fields and reset values
   localparam int unsigned   CTL_OPEN_REQ_BIT = 0;
   localparam int unsigned   CTL_MANUAL_BIT   = 1;
   localparam logic          CTL_OPEN_REQ_RST = 1'h1;
   localparam logic          CTL_MANUAL_RST   = 1'h1;

   // Service byte fields
   localparam int unsigned SVC_RSVD0_BIT   = 0;
   localparam int unsigned SVC_NO_OPEN_BIT = 1;
   localparam int unsigned SVC_NO_CLOSE_BIT = 2;
   localparam int unsigned SVC_PASSIV_BIT  = 3;
   localparam int unsigned SVC_RSVD4_BIT   = 4;
   localparam int unsigned SVC_STUCK_BIT   = 5;
   localparam int unsigned SVC_ACKREQ_BIT  = 6;
   localparam int unsigned SVC_ENABLE_BIT  = 7;
   localparam logic [7:0]  SVC_RST         = 8'h00;

   // Status register fields
   localparam int unsigned STS_STATE_LSB = 5;

   // Stuck confirm button detection time
   localparam int unsigned CLK_FREQ_HZ    = 25_000_000;
   localparam int unsigned STUCK_TIME_US  = 1000;
   localparam int unsigned STUCK_CYCLES   = STUCK_TIME_US * (CLK_FREQ_HZ / 1_000_000);

   typedef enum logic [2:0]
   {
      ST_STARTUP,
      ST_WAIT_OPEN,
      ST_WAIT_CLOSE,
      ST_WAIT_ACK,
      ST_ENABLED
   } sdm_state_type;

endpackage : sdm_pkg

//--- rtl/sdm_door_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Signals between the monitor core and its helpers
// ****************************************************************
interface sdm_door_if;
   logic       confirm_rise;
   logic       confirm_stuck;
   logic       need_open;
   logic       need_close;
   logic       passivated;
   logic       ack_request;
   logic       enable;
   logic [7:0] service_byte;

   modport cond
   (
      output confirm_rise,
      output confirm_stuck
   );
   modport svc
   (
      input  need_open,
      input  need_close,
      input  passivated,
      input  confirm_stuck,
      input  ack_request,
      input  enable,
      output service_byte
   );
   modport core
   (
      input  confirm_rise,
      input  confirm_stuck,
      input  service_byte,
      output need_open,
      output need_close,
      output passivated,
      output ack_request,
      output enable
   );
endinterface : sdm_door_if
`default_nettype wire

//--- rtl/sdm_confirm_cond.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Confirm button edge and stuck detection
// ****************************************************************
module sdm_confirm_cond
#(
   parameter int unsigned STUCK_CYCLES = sdm_pkg::STUCK_CYCLES
)
(
   input  wire logic core_clk_i,   // System clock
   input  wire logic resetn_i,     // Async reset, active low
   input  wire logic ce_i,         // Clock enable
   input  wire logic confirm_i,    // Confirm button level
   sdm_door_if.cond  door          // Edge and stuck flags
);
   import sdm_pkg::*;

   localparam int unsigned CNT_W = $clog2(STUCK_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(STUCK_CYCLES);

   logic             confirm_prev;
   logic [CNT_W-1:0] held_cnt;

   // Previous level starts high so a button held through reset gives no edge
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         confirm_prev <= 1'b1;
      else if (ce_i)
         confirm_prev <= confirm_i;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         held_cnt <= '0;
      else if (ce_i)
      begin
         if (!confirm_i)
            held_cnt <= '0;
         else if (held_cnt != CNT_MAX)
            held_cnt <= held_cnt + CNT_W'(1);
      end
   end

   assign door.confirm_rise  = confirm_i & ~confirm_prev;
   assign door.confirm_stuck = (held_cnt == CNT_MAX);

endmodule : sdm_confirm_cond
`default_nettype wire

//--- rtl/sdm_service_enc.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Service byte register
// ****************************************************************
module sdm_service_enc
(
   input  wire logic core_clk_i,   // System clock
   input  wire logic resetn_i,     // Async reset, active low
   input  wire logic ce_i,         // Clock enable
   sdm_door_if.svc   door          // Flags in, byte out
);
   import sdm_pkg::*;

   logic [7:0] next_byte;

   always_comb
   begin
      next_byte = 8'h00;
      next_byte[SVC_RSVD0_BIT] = 1'b0;
      next_byte[SVC_RSVD4_BIT] = 1'b0;
      next_byte[SVC_NO_OPEN_BIT] = door.need_open;
      next_byte[SVC_NO_CLOSE_BIT] = door.need_close;
      next_byte[SVC_PASSIV_BIT] = door.passivated;
      next_byte[SVC_STUCK_BIT] = door.confirm_stuck & ~door.enable;
      next_byte[SVC_ACKREQ_BIT] = door.ack_request;
      next_byte[SVC_ENABLE_BIT] = door.enable;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         door.service_byte <= SVC_RST;
      else if (ce_i)
         door.service_byte <= next_byte;
   end

endmodule : sdm_service_enc
`default_nettype wire

//--- rtl/sdm_safety_door_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Safety door monitor with AXI4-Lite register access
// ****************************************************************

module sdm_safety_door_monitor
#(
   parameter int unsigned STUCK_CYCLES = sdm_pkg::STUCK_CYCLES
)
(
   input  wire logic                            core_clk_i,            // System clock
   input  wire logic                            resetn_i,              // Async reset, active low
   input  wire logic                            ce_i,                  // Clock enable
   input  wire logic                            switch_a_in_i,         // Opener contact, 1 = closed
   input  wire logic                            switch_b_in_i,         // Closer contact, 1 = closed
   input  wire logic                            switch_a_passivated_i, // Channel A passivated
   input  wire logic                            switch_b_passivated_i, // Channel B passivated
   input  wire logic                            confirm_i,             // Acknowledge button
   output logic                                 door_enable_o,         // 1 = door closed, enabled
   output logic                                 ack_request_o,         // Acknowledge wanted
   output logic [7:0]                           service_info_byte_o,   // Diagnostic byte
   input  wire logic [sdm_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,          // Write address
   input  wire logic [2:0]                      s_axi_awprot,          // Unused protection
   input  wire logic                            s_axi_awvalid,         // Write address valid
   output logic                                 s_axi_awready,         // Write address ready
   input  wire logic [sdm_pkg::AXI_DATA_W-1:0]  s_axi_wdata,           // Write data
   input  wire logic [3:0]                      s_axi_wstrb,           // Write strobes
   input  wire logic                            s_axi_wvalid,          // Write data valid
   output logic                                 s_axi_wready,          // Write data ready
   output logic [1:0]                           s_axi_bresp,           // Write response
   output logic                                 s_axi_bvalid,          // Write response valid
   input  wire logic                            s_axi_bready,          // Write response ready
   input  wire logic [sdm_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,          // Read address
   input  wire logic [2:0]                      s_axi_arprot,          // Unused protection
   input  wire logic                            s_axi_arvalid,         // Read address valid
   output logic                                 s_axi_arready,         // Read address ready
   output logic [sdm_pkg::AXI_DATA_W-1:0]       s_axi_rdata,           // Read data
   output logic [1:0]                           s_axi_rresp,           // Read response
   output logic                                 s_axi_rvalid,          // Read data valid
   input  wire logic                            s_axi_rready           // Read data ready
);
   import sdm_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   sdm_door_if door ();

   sdm_state_type             state;
   sdm_state_type             next_state;
   logic                      enable;
   logic                      ack_request;
   logic                      open_required_at_startup;
   logic                      manual_confirm_mode;
   logic                      both_closed;
   logic                      both_open;
   logic                      any_open;
   logic                      any_passivated;
   logic                      opened_ok;

   logic                      aw_held;
   logic                      w_held;
   logic [AXI_ADDR_W-1:0]     aw_addr;
   logic [AXI_DATA_W-1:0]     w_data;
   logic [3:0]                w_strb;
   logic                      do_write;
   logic                      ar_take;

   // Register select: 0 none, 1 service, 2 control, 3 status
   function automatic logic [1:0] reg_sel(input logic [AXI_ADDR_W-1:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr == OFS_SERVICE)
         sel = 2'h1;
      else if (addr == OFS_CONTROL)
         sel = 2'h2;
      else if (addr == OFS_STATUS)
         sel = 2'h3;
      return sel;
   endfunction : reg_sel

   // ****************************************************************
   // Helpers
   // ****************************************************************
   sdm_confirm_cond
   #(
      .STUCK_CYCLES (STUCK_CYCLES)
   )
   u_confirm
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .ce_i       (ce_i),
      .confirm_i  (confirm_i),
      .door       (door.cond)
   );

   sdm_service_enc u_service
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .ce_i       (ce_i),
      .door       (door.svc)
   );

   // ****************************************************************
   // Door state machine
   // ****************************************************************
   assign both_closed    = switch_a_in_i & switch_b_in_i;
   assign both_open      = ~switch_a_in_i & ~switch_b_in_i;
   assign any_open       = ~switch_a_in_i | ~switch_b_in_i;
   assign any_passivated = switch_a_passivated_i | switch_b_passivated_i;
   // Low from passivation counts as opened
   assign opened_ok      = both_open | (~switch_a_in_i & switch_a_passivated_i)
                                     | (~switch_b_in_i & switch_b_passivated_i);

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_STARTUP:
         begin
            // Decision waits for both channels to be reintegrated
            if (!any_passivated)
            begin
               if (!open_required_at_startup && both_closed)
                  next_state = ST_ENABLED;
               else
                  next_state = ST_WAIT_OPEN;
            end
         end
         ST_WAIT_OPEN:
         begin
            if (opened_ok)
               next_state = ST_WAIT_CLOSE;
         end
         ST_WAIT_CLOSE:
         begin
            if (both_closed && !any_passivated)
               next_state = ST_WAIT_ACK;
         end
         ST_WAIT_ACK:
         begin
            if (any_open)
               next_state = opened_ok ? ST_WAIT_CLOSE : ST_WAIT_OPEN;
            else if (!manual_confirm_mode || door.confirm_rise)
               next_state = ST_ENABLED;
         end
         ST_ENABLED:
         begin
            if (any_open)
               next_state = opened_ok ? ST_WAIT_CLOSE : ST_WAIT_OPEN;
         end
         default:
            next_state = ST_STARTUP;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state <= ST_STARTUP;
      else if (ce_i)
         state <= next_state;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         enable <= 1'b0;
      else if (ce_i)
         enable <= (next_state == ST_ENABLED);
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ack_request <= 1'b0;
      else if (ce_i)
         ack_request <= (next_state == ST_WAIT_ACK);
   end

   // Gated by switches so opening acts in the same cycle
   assign door_enable_o  = enable & both_closed;
   assign ack_request_o  = ack_request;

   assign door.enable      = door_enable_o;
   assign door.ack_request = ack_request;
   assign door.passivated  = any_passivated;
   assign door.need_open   = (state == ST_WAIT_OPEN)
                           | ((state == ST_STARTUP) & open_required_at_startup);
   assign door.need_close  = (state == ST_STARTUP) | (state == ST_WAIT_OPEN)
                           | (state == ST_WAIT_CLOSE);

   // Diagnostic only, never feeds the enable path
   assign service_info_byte_o = door.service_byte;

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   // Ready gated by ce_i so no beat is taken while frozen
   assign s_axi_awready = ce_i & ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ce_i & ~w_held & ~s_axi_bvalid;
   assign do_write      = ce_i & aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         open_required_at_startup <= CTL_OPEN_REQ_RST;
         manual_confirm_mode      <= CTL_MANUAL_RST;
      end
      else if (do_write && reg_sel(aw_addr) == 2'h2 && w_strb[0])
      begin
         open_required_at_startup <= w_data[CTL_OPEN_REQ_BIT];
         manual_confirm_mode      <= w_data[CTL_MANUAL_BIT];
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (reg_sel(aw_addr) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (ce_i && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   assign s_axi_arready = ce_i & ~s_axi_rvalid;
   assign ar_take       = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (reg_sel(s_axi_araddr))
            2'h1:
               s_axi_rdata <= {24'h000000, door.service_byte};
            2'h2:
               s_axi_rdata <= {30'h00000000, manual_confirm_mode, open_required_at_startup};
            2'h3:
               s_axi_rdata <= {24'h000000, state, confirm_i, switch_b_passivated_i,
                               switch_a_passivated_i, switch_b_in_i, switch_a_in_i};
            2'h0:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (ce_i && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule : sdm_safety_door_monitor
`default_nettype wire

//--- verification/sdm_door_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// Door switches and confirm button
// ******
module sdm_door_model
(
   input  wire logic       core_clk_i, // Clock
   input  wire logic [1:0] pos_i,      // Bit0 switch A, bit1 B
   input  wire logic       press_i,    // Button pushed
   output logic            switch_a_o, // Opener contact
   output logic            switch_b_o, // Closer contact
   output logic            confirm_o   // Button contact
);
   always @(posedge core_clk_i)
   begin
      switch_a_o <= pos_i[0];
      switch_b_o <= pos_i[1];
      confirm_o <= press_i;
   end
endmodule : sdm_door_model
`default_nettype wire

//--- verification/sdm_monitor_props.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// Port checks of the door monitor
// ******
module sdm_monitor_props
#(
   parameter int unsigned STUCK_CYCLES = 8
)
(
   input wire logic       core_clk_i,            // Clock
   input wire logic       resetn_i,              // Reset
   input wire logic       switch_a_in_i,         // Switch A
   input wire logic       switch_b_in_i,         // Switch B
   input wire logic       switch_a_passivated_i, // Passivated A
   input wire logic       switch_b_passivated_i, // Passivated B
   input wire logic       confirm_i,             // Button
   input wire logic       door_enable_o,         // Enable
   input wire logic       ack_request_o,         // Request
   input wire logic [7:0] service_info_byte_o    // Service byte
);
   logic [7:0]  svc;
   logic        shut;
   logic        pas;
   int unsigned stuck_cnt;
   assign svc = service_info_byte_o;
   assign shut = switch_a_in_i && switch_b_in_i;
   assign pas = switch_a_passivated_i || switch_b_passivated_i;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // Held button, enable absent
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         stuck_cnt <= 32'h0;
      else if (confirm_i && !door_enable_o)
         stuck_cnt <= stuck_cnt + 32'h1;
      else
         stuck_cnt <= 32'h0;
   end
   AST_STARTUP_LOW: assert property ($rose(resetn_i) |-> !door_enable_o ##1 !door_enable_o)
      else $error("enable high right after reset");
   AST_EN_GATE: assert property (door_enable_o |-> shut)
      else $error("enable high with a switch open");
   AST_SVC_RSVD: assert property (!svc[0] && !svc[4])
      else $error("reserved service bit set");
   AST_SVC_ACK: assert property (1'h1 |=> svc[6] == $past(ack_request_o))
      else $error("service bit 6 differs from request");
   AST_SVC_EN: assert property ($stable(door_enable_o) |=> svc[7] == $past(door_enable_o))
      else $error("service bit 7 differs from enable");
   AST_SVC_PASS: assert property (pas [*3] |=> svc[3])
      else $error("service bit 3 missing");
   AST_ACK_RISE: assert property ($rose(ack_request_o) |-> $past(shut && !pas))
      else $error("request raised with door not closed");
   AST_ACK_FALL: assert property ($fell(ack_request_o) && shut && $past(shut) |-> door_enable_o)
      else $error("request dropped without enable");
   AST_STUCK: assert property (stuck_cnt > STUCK_CYCLES + 2 |-> svc[5])
      else $error("stuck button not flagged");
   COV_ACK: cover property ($rose(ack_request_o));
   COV_EN: cover property ($rose(door_enable_o));
   COV_STUCK: cover property ($rose(svc[5]));
endmodule : sdm_monitor_props
bind sdm_safety_door_monitor sdm_monitor_props #(.STUCK_CYCLES(STUCK_CYCLES)) u_sdm_monitor_props
(
   .core_clk_i, .resetn_i, .switch_a_in_i, .switch_b_in_i, .switch_a_passivated_i,
   .switch_b_passivated_i, .confirm_i, .door_enable_o, .ack_request_o, .service_info_byte_o
);
`default_nettype wire

//--- verification/tb_safety_door_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_safety_door_monitor;
   import sdm_pkg::*;
   localparam int unsigned STK = 8;
   logic        core_clk_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1;
   logic [1:0]  pos = 2'h1;
   logic        press = 1'h0, pas_a = 1'h0, pas_b = 1'h0;
   logic        sw_a, sw_b, conf, en, ackr;
   logic [7:0]  svc;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [2:0]  prot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [1:0]  bq[$];
   logic [33:0] rq[$];
   integer      seed = 32'h99E122BB;
   int          n_mismatch = 0, n_checks = 0, cyc = 0;
   sdm_door_model u_sdm_door_model
   (
      .core_clk_i, .pos_i(pos), .press_i(press),
      .switch_a_o(sw_a), .switch_b_o(sw_b), .confirm_o(conf)
   );
   sdm_safety_door_monitor #(.STUCK_CYCLES(STK)) u_sdm_safety_door_monitor
   (
      .core_clk_i, .resetn_i, .ce_i, .switch_a_in_i(sw_a), .switch_b_in_i(sw_b),
      .switch_a_passivated_i(pas_a), .switch_b_passivated_i(pas_b),
      .confirm_i(conf), .door_enable_o(en), .ack_request_o(ackr),
      .service_info_byte_o(svc), .s_axi_awaddr, .s_axi_awprot(prot),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   always #20 core_clk_i = ~core_clk_i;
   // ******
   // Helpers
   // ******
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : tick
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta;
      logic tw;
      @(posedge core_clk_i);
      bq.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      ta = 1'h0;
      tw = 1'h0;
      while (!(ta && tw))
      begin
         @(negedge core_clk_i);
         ta = ta || s_axi_awready;
         tw = tw || s_axi_wready;
         @(posedge core_clk_i);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end
      do @(negedge core_clk_i); while (!s_axi_bvalid);
      @(posedge core_clk_i);
      s_axi_bready <= 1'h0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge core_clk_i);
      rq.push_back({e, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(negedge core_clk_i); while (!s_axi_arready);
      @(posedge core_clk_i);
      s_axi_arvalid <= 1'h0;
      do @(negedge core_clk_i); while (!s_axi_rvalid);
      @(posedge core_clk_i);
      s_axi_rready <= 1'h0;
   endtask : rd
   // ******
   // Response watcher and timeout
   // ******
   always @(negedge core_clk_i)
   begin
      logic [33:0] e;
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
      if (s_axi_rvalid && s_axi_rready)
      begin
         e = rq.pop_front();
         chk("rdata", s_axi_rdata, e[31:0]);
         chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[33:32]});
      end
   end
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   // ******
   // Scenarios
   // ******
   initial
   begin
      tick(6);
      resetn_i <= 1'h1;
      rd(OFS_CONTROL, 32'h3, RESP_OKAY);
      rd(OFS_SERVICE, 32'h06, RESP_OKAY);
      rd(4'hC, 32'h0, RESP_SLVERR);
      wr(4'hC, 32'h0, RESP_SLVERR);
      wr(OFS_SERVICE, 32'hFF, RESP_OKAY);
      pos <= 2'h0;
      tick(4);
      rd(OFS_SERVICE, 32'h04, RESP_OKAY);
      pos <= 2'h3;
      tick(4);
      chk("ackreq", 32'(ackr), 32'h1);
      chk("enable", 32'(en), 32'h0);
      rd(OFS_SERVICE, 32'h40, RESP_OKAY);
      rd(OFS_STATUS, 32'h63, RESP_OKAY);
      // Frozen clock enable must hold off the confirm edge
      ce_i <= 1'h0;
      press <= 1'h1;
      tick(4);
      chk("ackreq", 32'(ackr), 32'h1);
      chk("enable", 32'(en), 32'h0);
      ce_i <= 1'h1;
      tick(4);
      chk("enable", 32'(en), 32'h1);
      chk("ackreq", 32'(ackr), 32'h0);
      rd(OFS_SERVICE, 32'h80, RESP_OKAY);
      press <= 1'h0;
      pos <= 2'h1;
      tick(1);
      @(negedge core_clk_i);
      chk("enable", 32'(en), 32'h0);
      tick(3);
      pos <= 2'h3;
      tick(4);
      chk("ackreq", 32'(ackr), 32'h0);
      rd(OFS_SERVICE, 32'h06, RESP_OKAY);
      pos <= 2'h1;
      pas_b <= 1'h1;
      tick(4);
      rd(OFS_SERVICE, 32'h0C, RESP_OKAY);
      chk("svcbyte", 32'(svc), 32'h0C);
      pas_b <= 1'h0;
      pos <= 2'h3;
      tick(4);
      chk("ackreq", 32'(ackr), 32'h1);
      wr(OFS_CONTROL, 32'h0, RESP_OKAY);
      tick(3);
      chk("enable", 32'(en), 32'h1);
      resetn_i <= 1'h0;
      pas_a <= 1'h1;
      tick(6);
      resetn_i <= 1'h1;
      wr(OFS_CONTROL, 32'h0, RESP_OKAY);
      tick(2);
      chk("enable", 32'(en), 32'h0);
      pas_a <= 1'h0;
      tick(4);
      chk("enable", 32'(en), 32'h1);
      chk("ackreq", 32'(ackr), 32'h0);
      pos <= 2'h0;
      press <= 1'h1;
      tick(STK + 8);
      rd(OFS_SERVICE, 32'h24, RESP_OKAY);
      chk("svcbyte", 32'(svc), 32'h24);
      press <= 1'h0;
      // Random door traffic, judged by the checker
      repeat (300)
      begin
         @(posedge core_clk_i);
         r = $random(seed);
         pos <= r[1:0];
         press <= r[2];
         pas_a <= r[5:3] == 3'h0;
         pas_b <= r[8:6] == 3'h0;
      end
      stop_test();
   end
endmodule : tb_safety_door_monitor
`default_nettype wire
